// ### dual_timer_pkg.sv
// constants, field layouts and state record for the dual timer block
// assumes a 32-bit APB slave port clocked by pclk at 100 MHz
`default_nettype none

package dual_timer_pkg;

	localparam int CNT_W = 16;
	localparam int PS_W  = 5;
	localparam int SEL_W = 3;
	localparam int AW    = 12;
	localparam int DW    = 32;

	// register byte offsets, one aligned word each
	localparam logic [AW-1:0] OFS_PRESCALE  = 12'h000;
	localparam logic [AW-1:0] OFS_CLK_SEL   = 12'h004;
	localparam logic [AW-1:0] OFS_CNT_ONE   = 12'h008;
	localparam logic [AW-1:0] OFS_CNT_TWO   = 12'h00C;
	localparam logic [AW-1:0] OFS_RELOAD_A  = 12'h010;
	localparam logic [AW-1:0] OFS_RELOAD_B  = 12'h014;
	localparam logic [AW-1:0] OFS_MODE_CTL  = 12'h018;
	localparam logic [AW-1:0] OFS_IRQ_EN    = 12'h01C;
	localparam logic [AW-1:0] OFS_PENDING   = 12'h020;
	localparam logic [AW-1:0] OFS_PEND_CLR  = 12'h024;

	// clock select field layout and codes
	localparam int SEL1_LSB = 0;
	localparam int SEL2_LSB = 3;
	localparam logic [SEL_W-1:0] CSEL_STOP     = 3'h0;
	localparam logic [SEL_W-1:0] CSEL_PRESCALE = 3'h1;
	localparam logic [SEL_W-1:0] CSEL_SLOW     = 3'h4;

	// mode control field positions
	localparam int MODE_LSB     = 0;
	localparam int PIN_ACT_BIT  = 2;
	localparam int CAP_RISE_BIT = 3;
	localparam int PIN_INIT_BIT = 4;

	// pending / enable bit positions
	localparam int EV_A = 0;
	localparam int EV_B = 1;
	localparam int EV_C = 2;
	localparam int EV_D = 3;
	localparam int EV_N = 4;

	localparam logic [CNT_W-1:0] CNT_ONES   = 16'hFFFF;
	localparam logic [CNT_W-1:0] CNT_ZERO   = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_STEP   = 16'h0001;
	localparam logic [PS_W-1:0]  PS_ZERO    = 5'h00;
	localparam logic [PS_W-1:0]  PS_STEP    = 5'h01;
	localparam logic [CNT_W-1:0] RELOAD_RST = 16'h0000;
	localparam logic [DW-1:0]    DATA_ZERO  = 32'h00000000;

	typedef enum logic [1:0] {
		MODE_IDLE,
		MODE_PWM,
		MODE_CAPTURE,
		MODE_RESERVED
	} mode_t;

	typedef struct packed {
		logic          psel;
		logic          penable;
		logic          pwrite;
		logic [AW-1:0] paddr;
		logic [DW-1:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [PS_W-1:0]  prescale_div;
		logic [PS_W-1:0]  prescale_cnt;
		logic [SEL_W-1:0] clk_sel1;
		logic [SEL_W-1:0] clk_sel2;
		logic [CNT_W-1:0] first_counter;
		logic [CNT_W-1:0] second_counter;
		logic [CNT_W-1:0] reload_capture_a;
		logic [CNT_W-1:0] reload_capture_b;
		mode_t            mode;
		logic             pin_act_en;
		logic             cap_rising;
		logic             pin_initial_level;
		logic [EV_N-1:0]  irq_en;
		logic [EV_N-1:0]  pending;
		logic             use_b;
		logic             slow_meta;
		logic             slow_sync;
		logic             slow_prev;
		logic             pin_prev;
		logic             pin_level;
		logic             pin_oe;
		logic             pready;
		logic [DW-1:0]    prdata;
		logic             pslverr;
		logic             irq_timer1;
		logic             irq_timer2;
	} state_t;

endpackage

`default_nettype wire

// ### dual_timer_pwm_capture.sv
// dual 16-bit down-counting timer: PWM and input capture modes
// assumes APB master on pclk, pin input and slow clock as plain inputs
`default_nettype none
`timescale 1ns/1ps

// Overview of operation
// - two counters, two reload/capture registers
// - each counter picks stop, prescaled, slow clock
// - prescaler divides system clock by divisor+1
// - reset clears prescale divisor and counter
// - slow clock synchronised before clocking counters
// - counters hold while system clock stops
// - counters disabled after reset until programmed
// - PWM reloads alternately from A then B
// - restart after select 000 or leaving PWM reloads first from A
// - PWM toggle inverts pin per underflow
// - PWM sets A on A-reload, B on B-reload
// - second counter underflow sets event D
// - capture edge copies first counter into A
// - capture preset loads all ones after copy
// - capture mode events: edge A, underflow C
// - select codes 000 stop, 001 prescale, 100 slow
// - select 001 or 100 starts counter; reset clears selects
// - pin starts at software initial-level bit
module dual_timer_pwm_capture (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire dual_timer_pkg::apb_req_t apb_req,
	output logic                          pready,
	output logic [dual_timer_pkg::DW-1:0] prdata,
	output logic                          pslverr,
	input  wire logic                     slow_clk,
	input  wire logic                     timer_io_pin_in,
	output logic                          timer_io_pin_out,
	output logic                          timer_io_pin_oe,
	output logic                          irq_timer1,
	output logic                          irq_timer2
);

	dual_timer_pkg::state_t q;
	dual_timer_pkg::state_t d;

	logic                                slow_tick;
	logic                                pre_tick;
	logic                                tick1;
	logic                                tick2;
	logic                                pwm;
	logic                                cap;
	logic                                active;
	logic                                stop1;
	logic                                cap_evt;
	logic                                rd_phase;
	logic                                wr_en;
	logic                                mapped;
	logic [dual_timer_pkg::EV_N-1:0]     ev_set;
	logic [dual_timer_pkg::EV_N-1:0]     ev_clr;
	logic [dual_timer_pkg::DW-1:0]       rd_val;

	// reserved select codes act as no clock
	function automatic logic sel_tick(
		input logic [dual_timer_pkg::SEL_W-1:0] sel,
		input logic                             pre,
		input logic                             slow
	);
		logic t;
		t = 1'b0;
		case (sel)
			dual_timer_pkg::CSEL_PRESCALE: t = pre;
			dual_timer_pkg::CSEL_SLOW:     t = slow;
			default:                       t = 1'b0;
		endcase
		return t;
	endfunction

	always_comb begin
		d       = q;
		ev_set  = '0;
		ev_clr  = '0;
		rd_val  = dual_timer_pkg::DATA_ZERO;
		mapped  = 1'b1;

		// slow clock: meta flop feeds only the sync flop
		d.slow_meta = slow_clk;
		d.slow_sync = q.slow_meta;
		d.slow_prev = q.slow_sync;
		slow_tick   = q.slow_sync & ~q.slow_prev;

		// prescaler: tick every divisor+1 system clocks
		// a new divisor is picked up at the next reload, no short tick
		pre_tick = (q.prescale_cnt == dual_timer_pkg::PS_ZERO);
		if (pre_tick) begin
			d.prescale_cnt = q.prescale_div;
		end else begin
			d.prescale_cnt = q.prescale_cnt - dual_timer_pkg::PS_STEP;
		end

		tick1  = sel_tick(q.clk_sel1, pre_tick, slow_tick);
		tick2  = sel_tick(q.clk_sel2, pre_tick, slow_tick);
		pwm    = (q.mode == dual_timer_pkg::MODE_PWM);
		cap    = (q.mode == dual_timer_pkg::MODE_CAPTURE);
		active = pwm | cap;
		stop1  = (q.clk_sel1 == dual_timer_pkg::CSEL_STOP);

		// first counter
		if (active && tick1) begin
			if (q.first_counter == dual_timer_pkg::CNT_ZERO) begin
				if (pwm) begin
					if (q.use_b) begin
						d.first_counter = q.reload_capture_b;
						ev_set[dual_timer_pkg::EV_B] = 1'b1;
					end else begin
						d.first_counter = q.reload_capture_a;
						ev_set[dual_timer_pkg::EV_A] = 1'b1;
					end
					d.use_b = ~q.use_b;
					if (q.pin_act_en) begin
						d.pin_level = ~q.pin_level;
					end
				end else begin
					d.first_counter = dual_timer_pkg::CNT_ONES;
					ev_set[dual_timer_pkg::EV_C] = 1'b1;
				end
			end else begin
				d.first_counter = q.first_counter - dual_timer_pkg::CNT_STEP;
			end
		end

		// select 000 or left PWM: next start reloads from A first
		if (!pwm || stop1) begin
			d.use_b = 1'b0;
		end
		// pin parks at initial level until the toggling runs
		if (!pwm || stop1 || !q.pin_act_en) begin
			d.pin_level = q.pin_initial_level;
		end
		d.pin_oe = pwm & q.pin_act_en;

		// capture: pin taken as synchronous, one level per clock min
		// limitation: enable drops a cycle after leaving PWM, so the
		// last driven level can read as one capture edge
		d.pin_prev = timer_io_pin_in;
		cap_evt = cap & (q.cap_rising ?
			(timer_io_pin_in & ~q.pin_prev) :
			(~timer_io_pin_in & q.pin_prev));
		if (cap_evt) begin
			d.reload_capture_a = q.first_counter;
			ev_set[dual_timer_pkg::EV_A] = 1'b1;
			// preset shares the pin action bit with the PWM toggle
			if (q.pin_act_en) begin
				d.first_counter = dual_timer_pkg::CNT_ONES;
			end
		end

		// second counter: general timer in both modes
		if (active && tick2) begin
			if (q.second_counter == dual_timer_pkg::CNT_ZERO) begin
				d.second_counter = dual_timer_pkg::CNT_ONES;
				ev_set[dual_timer_pkg::EV_D] = 1'b1;
			end else begin
				d.second_counter = q.second_counter - dual_timer_pkg::CNT_STEP;
			end
		end

		// APB: first access cycle registers the answer
		// the write waits for the edge at which the master sees pready
		rd_phase = apb_req.psel & apb_req.penable & ~q.pready;
		wr_en    = apb_req.psel & apb_req.penable & apb_req.pwrite & q.pready;
		case (apb_req.paddr)
			dual_timer_pkg::OFS_PRESCALE:
				rd_val[dual_timer_pkg::PS_W-1:0] = q.prescale_div;
			dual_timer_pkg::OFS_CLK_SEL: begin
				rd_val[dual_timer_pkg::SEL1_LSB +: dual_timer_pkg::SEL_W] =
					q.clk_sel1;
				rd_val[dual_timer_pkg::SEL2_LSB +: dual_timer_pkg::SEL_W] =
					q.clk_sel2;
			end
			dual_timer_pkg::OFS_CNT_ONE:
				rd_val[dual_timer_pkg::CNT_W-1:0] = q.first_counter;
			dual_timer_pkg::OFS_CNT_TWO:
				rd_val[dual_timer_pkg::CNT_W-1:0] = q.second_counter;
			dual_timer_pkg::OFS_RELOAD_A:
				rd_val[dual_timer_pkg::CNT_W-1:0] = q.reload_capture_a;
			dual_timer_pkg::OFS_RELOAD_B:
				rd_val[dual_timer_pkg::CNT_W-1:0] = q.reload_capture_b;
			dual_timer_pkg::OFS_MODE_CTL: begin
				rd_val[dual_timer_pkg::MODE_LSB +:
					$bits(dual_timer_pkg::mode_t)] = q.mode;
				rd_val[dual_timer_pkg::PIN_ACT_BIT]   = q.pin_act_en;
				rd_val[dual_timer_pkg::CAP_RISE_BIT]  = q.cap_rising;
				rd_val[dual_timer_pkg::PIN_INIT_BIT]  = q.pin_initial_level;
			end
			dual_timer_pkg::OFS_IRQ_EN:
				rd_val[dual_timer_pkg::EV_N-1:0] = q.irq_en;
			dual_timer_pkg::OFS_PENDING:
				rd_val[dual_timer_pkg::EV_N-1:0] = q.pending;
			dual_timer_pkg::OFS_PEND_CLR:
				rd_val = dual_timer_pkg::DATA_ZERO;
			default:
				mapped = 1'b0;
		endcase

		d.pready = rd_phase;
		if (rd_phase) begin
			d.prdata  = apb_req.pwrite ? dual_timer_pkg::DATA_ZERO : rd_val;
			d.pslverr = ~mapped;
		end

		// software writes other than the pending clear land after hardware updates and win
		if (wr_en) begin
			case (apb_req.paddr)
				dual_timer_pkg::OFS_PRESCALE:
					d.prescale_div = apb_req.pwdata[dual_timer_pkg::PS_W-1:0];
				dual_timer_pkg::OFS_CLK_SEL: begin
					d.clk_sel1 = apb_req.pwdata[dual_timer_pkg::SEL1_LSB +:
						dual_timer_pkg::SEL_W];
					d.clk_sel2 = apb_req.pwdata[dual_timer_pkg::SEL2_LSB +:
						dual_timer_pkg::SEL_W];
				end
				dual_timer_pkg::OFS_CNT_ONE:
					d.first_counter =
						apb_req.pwdata[dual_timer_pkg::CNT_W-1:0];
				dual_timer_pkg::OFS_CNT_TWO:
					d.second_counter =
						apb_req.pwdata[dual_timer_pkg::CNT_W-1:0];
				dual_timer_pkg::OFS_RELOAD_A:
					d.reload_capture_a =
						apb_req.pwdata[dual_timer_pkg::CNT_W-1:0];
				dual_timer_pkg::OFS_RELOAD_B:
					d.reload_capture_b =
						apb_req.pwdata[dual_timer_pkg::CNT_W-1:0];
				dual_timer_pkg::OFS_MODE_CTL: begin
					d.mode = dual_timer_pkg::mode_t'(
						apb_req.pwdata[dual_timer_pkg::MODE_LSB +:
						$bits(dual_timer_pkg::mode_t)]);
					d.pin_act_en = apb_req.pwdata[dual_timer_pkg::PIN_ACT_BIT];
					d.cap_rising = apb_req.pwdata[dual_timer_pkg::CAP_RISE_BIT];
					d.pin_initial_level =
						apb_req.pwdata[dual_timer_pkg::PIN_INIT_BIT];
				end
				dual_timer_pkg::OFS_IRQ_EN:
					d.irq_en = apb_req.pwdata[dual_timer_pkg::EV_N-1:0];
				dual_timer_pkg::OFS_PEND_CLR:
					ev_clr = apb_req.pwdata[dual_timer_pkg::EV_N-1:0];
				default: ;
			endcase
		end

		// sticky pending; a same-cycle event beats the clear
		d.pending = (q.pending & ~ev_clr) | ev_set;
		d.irq_timer1 = |(d.pending[dual_timer_pkg::EV_C:dual_timer_pkg::EV_A]
			& d.irq_en[dual_timer_pkg::EV_C:dual_timer_pkg::EV_A]);
		d.irq_timer2 = d.pending[dual_timer_pkg::EV_D]
			& d.irq_en[dual_timer_pkg::EV_D];
	end

	// no clock means no edge: counters simply hold while it is stopped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// every field named: outputs and flags come up quiet
			q.prescale_div      <= dual_timer_pkg::PS_ZERO;
			q.prescale_cnt      <= dual_timer_pkg::PS_ZERO;
			q.clk_sel1          <= dual_timer_pkg::CSEL_STOP;
			q.clk_sel2          <= dual_timer_pkg::CSEL_STOP;
			q.first_counter     <= dual_timer_pkg::CNT_ZERO;
			q.second_counter    <= dual_timer_pkg::CNT_ZERO;
			q.reload_capture_a  <= dual_timer_pkg::RELOAD_RST;
			q.reload_capture_b  <= dual_timer_pkg::RELOAD_RST;
			q.mode              <= dual_timer_pkg::MODE_IDLE;
			q.use_b             <= 1'b0;
			q.pin_act_en        <= 1'b0;
			q.cap_rising        <= 1'b0;
			q.pin_initial_level <= 1'b0;
			q.irq_en            <= '0;
			q.pending           <= '0;
			q.slow_meta         <= 1'b0;
			q.slow_sync         <= 1'b0;
			q.slow_prev         <= 1'b0;
			q.pin_prev          <= 1'b0;
			q.pin_level         <= 1'b0;
			q.pin_oe            <= 1'b0;
			q.pready            <= 1'b0;
			q.prdata            <= dual_timer_pkg::DATA_ZERO;
			q.pslverr           <= 1'b0;
			q.irq_timer1        <= 1'b0;
			q.irq_timer2        <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign pready           = q.pready;
	assign prdata           = q.prdata;
	assign pslverr          = q.pslverr;
	assign timer_io_pin_out = q.pin_level;
	assign timer_io_pin_oe  = q.pin_oe;
	assign irq_timer1       = q.irq_timer1;
	assign irq_timer2       = q.irq_timer2;

endmodule

`default_nettype wire

// ### dual_timer_pin_model.sv
// far-side model of the timer pin: an external level source
// assumes the block splits the pin into in, out and enable
`timescale 1ns/1ps
`default_nettype none
module dual_timer_pin_model (
	input  wire logic pclk,
	input  wire logic drive_level,
	input  wire logic pin_out,
	input  wire logic pin_oe,
	output logic      pin_in
);
	logic level_q;

	// registered, so every level lasts at least one clock
	always_ff @(posedge pclk) begin
		level_q <= drive_level;
	end

	// the block wins the wire while it drives
	assign pin_in = pin_oe ? pin_out : level_q;
endmodule
`default_nettype wire

// ### dual_timer_pwm_capture_asserts.sv
// concurrent checks on the dual timer block ports
// bound to dual_timer_pwm_capture; one clock, async reset
`timescale 1ns/1ps
`default_nettype none
module dual_timer_chk (
	input wire logic                          pclk,
	input wire logic                          presetn,
	input wire dual_timer_pkg::apb_req_t      apb_req,
	input wire logic                          pready,
	input wire logic [dual_timer_pkg::DW-1:0] prdata,
	input wire logic                          pslverr,
	input wire logic                          timer_io_pin_out,
	input wire logic                          timer_io_pin_oe,
	input wire logic                          irq_timer1,
	input wire logic                          irq_timer2
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_setup;
		apb_req.psel && !apb_req.penable;
	endsequence
	sequence s_access;
		apb_req.psel && apb_req.penable;
	endsequence

	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held");
	a_ready_early: assert property (s_setup |=> !pready)
		else $error("pready in setup");
	a_one_wait: assert property (s_setup ##1 s_access |=> pready)
		else $error("no answer after one wait");
	a_err_zero: assert property (pready && pslverr |-> prdata == '0)
		else $error("error answer with data");
	a_answer_hold: assert property (!pready |->
		$stable(pslverr) && $stable(prdata))
		else $error("answer moved");
	// pin moves on its own only while driven
	a_pin_cause: assert property ($changed(timer_io_pin_out)
		|-> timer_io_pin_oe || $past(timer_io_pin_oe) ||
		$past(pready) || $past(pready, 2))
		else $error("pin moved without cause");
	a_oe_cause: assert property ($changed(timer_io_pin_oe) |->
		$past(pready) || $past(pready, 2))
		else $error("enable moved without write");
	a_irq_sticky: assert property ($fell(irq_timer1) ||
		$fell(irq_timer2) |-> $past(pready) || $past(pready, 2))
		else $error("irq dropped without write");
	a_reset_quiet: assert property ($rose(presetn) |->
		!pready && !irq_timer1 && !irq_timer2 && !timer_io_pin_oe)
		else $error("outputs busy after reset");
endmodule

bind dual_timer_pwm_capture dual_timer_chk u_chk (.pclk, .presetn,
	.apb_req, .pready, .prdata, .pslverr, .timer_io_pin_out,
	.timer_io_pin_oe, .irq_timer1, .irq_timer2);
`default_nettype wire

// ### dual_timer_pwm_capture_tb.sv
// self-checking bench for the dual timer block
// assumes the package, pin model and checker compile first
`timescale 1ns/1ps
`default_nettype none
module dual_timer_pwm_capture_tb;
	logic                     pclk, presetn, slow_clk, drive_level;
	dual_timer_pkg::apb_req_t apb_req;
	logic                     pready, pslverr, pin_in, pin_out, pin_oe;
	logic                     irq_timer1, irq_timer2, e;
	logic [31:0]              prdata, q;
	int                       mismatches, n_compared, cyc, n;

	dual_timer_pwm_capture dut (.pclk, .presetn, .apb_req, .pready,
		.prdata, .pslverr, .slow_clk, .timer_io_pin_in(pin_in),
		.timer_io_pin_out(pin_out), .timer_io_pin_oe(pin_oe),
		.irq_timer1, .irq_timer2);
	dual_timer_pin_model far (.pclk, .drive_level, .pin_out, .pin_oe,
		.pin_in);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// whole run needs a few hundred cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			results();
		end
	end

	task results;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task chk(input string name, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// request held until pready is seen high at a rising edge
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		apb_req <= '0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task rd(input string name, input logic [11:0] a, input logic [31:0] x);
		xfer(1'b0, a, 32'h0);
		chk(name, q, x);
	endtask

	// cycles until the pin output next moves
	task gap;
		logic p;
		p = pin_out;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (pin_out === p && n < 200);
	endtask

	task t_reset;
		for (int i = 0; i < 10; i++) begin
			rd("reset value", 12'(4 * i), 32'h0);
		end
		xfer(1'b0, 12'h028, 32'h0);
		chk("unmapped error", 32'(e), 32'h1);
		chk("unmapped data", q, 32'h0);
		$display("reset test done");
	endtask

	task t_pwm;
		wr(dual_timer_pkg::OFS_RELOAD_A, 32'h3);
		wr(dual_timer_pkg::OFS_RELOAD_B, 32'h6);
		wr(dual_timer_pkg::OFS_PRESCALE, 32'h2);
		wr(dual_timer_pkg::OFS_IRQ_EN, 32'h1);
		wr(dual_timer_pkg::OFS_MODE_CTL, 32'h15);
		repeat (2) @(negedge pclk);
		chk("initial level", 32'(pin_out), 32'h1);
		chk("pin enable", 32'(pin_oe), 32'h1);
		wr(dual_timer_pkg::OFS_CLK_SEL, 32'h1);
		gap;
		gap;
		chk("a period", 32'(n), 32'hC);
		gap;
		chk("b period", 32'(n), 32'h15);
		// stop just after an A reload, while a reload from B would be next
		rd("events a b", dual_timer_pkg::OFS_PENDING, 32'h3);
		wr(dual_timer_pkg::OFS_CLK_SEL, 32'h0);
		chk("irq a", 32'(irq_timer1), 32'h1);
		wr(dual_timer_pkg::OFS_PEND_CLR, 32'hF);
		rd("cleared", dual_timer_pkg::OFS_PENDING, 32'h0);
		wr(dual_timer_pkg::OFS_CLK_SEL, 32'h1);
		gap;
		gap;
		chk("restart from a", 32'(n), 32'hC);
		wr(dual_timer_pkg::OFS_CLK_SEL, 32'h0);
		wr(dual_timer_pkg::OFS_PEND_CLR, 32'hF);
		$display("pwm test done");
	endtask

	task t_capture;
		wr(dual_timer_pkg::OFS_MODE_CTL, 32'hE);
		wr(dual_timer_pkg::OFS_CNT_ONE, 32'h1234);
		chk("pin released", 32'(pin_oe), 32'h0);
		drive_level <= 1'b1;
		repeat (3) @(posedge pclk);
		rd("rise capture", dual_timer_pkg::OFS_RELOAD_A, 32'h1234);
		rd("preset", dual_timer_pkg::OFS_CNT_ONE, 32'hFFFF);
		rd("edge event", dual_timer_pkg::OFS_PENDING, 32'h1);
		chk("irq edge", 32'(irq_timer1), 32'h1);
		wr(dual_timer_pkg::OFS_MODE_CTL, 32'h6);
		wr(dual_timer_pkg::OFS_CNT_ONE, 32'h0042);
		drive_level <= 1'b0;
		repeat (3) @(posedge pclk);
		rd("fall capture", dual_timer_pkg::OFS_RELOAD_A, 32'h0042);
		wr(dual_timer_pkg::OFS_CNT_ONE, 32'h0077);
		drive_level <= 1'b1;
		repeat (3) @(posedge pclk);
		rd("wrong edge", dual_timer_pkg::OFS_RELOAD_A, 32'h0042);
		// falling capture with the preset off leaves the count alone
		wr(dual_timer_pkg::OFS_MODE_CTL, 32'h2);
		wr(dual_timer_pkg::OFS_CNT_ONE, 32'h0055);
		drive_level <= 1'b0;
		repeat (3) @(posedge pclk);
		rd("plain capture", dual_timer_pkg::OFS_RELOAD_A, 32'h0055);
		rd("no preset", dual_timer_pkg::OFS_CNT_ONE, 32'h0055);
		$display("capture test done");
	endtask

	task t_counter2;
		wr(dual_timer_pkg::OFS_IRQ_EN, 32'h8);
		wr(dual_timer_pkg::OFS_PEND_CLR, 32'hF);
		wr(dual_timer_pkg::OFS_CNT_TWO, 32'h2);
		wr(dual_timer_pkg::OFS_CLK_SEL, 32'h8);
		n = 0;
		while (irq_timer2 !== 1'b1 && n < 50) begin
			@(negedge pclk);
			n++;
		end
		chk("irq d", 32'(irq_timer2), 32'h1);
		rd("event d", dual_timer_pkg::OFS_PENDING, 32'h8);
		wr(dual_timer_pkg::OFS_CLK_SEL, 32'h0);
		wr(dual_timer_pkg::OFS_PEND_CLR, 32'hF);
		repeat (2) @(negedge pclk);
		chk("irq d cleared", 32'(irq_timer2), 32'h0);
		$display("counter two test done");
	endtask

	task t_slow;
		wr(dual_timer_pkg::OFS_IRQ_EN, 32'h4);
		wr(dual_timer_pkg::OFS_CNT_ONE, 32'h1);
		wr(dual_timer_pkg::OFS_CLK_SEL, 32'h2);
		repeat (6) @(posedge pclk);
		rd("reserved stops", dual_timer_pkg::OFS_CNT_ONE, 32'h1);
		// slow clock is not the system clock here, so it may be selected
		wr(dual_timer_pkg::OFS_CLK_SEL, 32'h4);
		// slow clock at an eighth of the system rate
		repeat (3) begin
			repeat (4) @(posedge pclk);
			slow_clk <= 1'b1;
			repeat (4) @(posedge pclk);
			slow_clk <= 1'b0;
		end
		repeat (6) @(posedge pclk);
		wr(dual_timer_pkg::OFS_CLK_SEL, 32'h0);
		rd("slow count", dual_timer_pkg::OFS_CNT_ONE, 32'hFFFE);
		rd("event c", dual_timer_pkg::OFS_PENDING, 32'h4);
		chk("irq c", 32'(irq_timer1), 32'h1);
		$display("slow clock test done");
	endtask

	initial begin
		presetn = 1'b0;
		slow_clk = 1'b0;
		drive_level = 1'b0;
		apb_req = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_pwm;
		t_capture;
		t_counter2;
		t_slow;
		results;
	end
endmodule
`default_nettype wire
